// >>> rtl/switch_cfg_defs.vh
// Purpose: Shared constants for the switch configuration block
// Assumes: Serial register offsets and field layouts are local choices
// Notes: Included by the top module and its timer
`ifndef SWITCH_CFG_DEFS_VH
`define SWITCH_CFG_DEFS_VH

// Clock and termination pulse timing
// 100 ms at 100 MHz, sized to fit the 24-bit timer exactly
`define TERM_PULSE_CYCLES 24'h989680
`define TERM_TIMER_W 24

// Slave address: fixed upper bits, straps below
`define DEV_ADDR_UPPER 4'h9

// Switching mode encodings
`define MODE_QUAD 2'h0
`define MODE_DUAL 2'h1
`define MODE_SINGLE 2'h2
`define MODE_BAD 2'h3

// Serial register offsets
`define REG_FAST_MODES 8'h00
`define REG_AUX_MODES 8'h01
`define REG_PULSE_LO 8'h02
`define REG_PULSE_HI 8'h03
`define REG_RX_SET 8'h04
`define REG_BOOST 8'h05
`define REG_TX_SET 8'h06

// Field positions
`define FLD_DRIVE_EN 7
`define FLD_MODE_HI 5
`define FLD_MODE_LO 4
`define FLD_CHAN_HI 3
`define FLD_CHAN_LO 0
`define FLD_TERM_OFF 0
`define FLD_OTERM 0
`define FLD_OCUR 1
`define FLD_OBOOST_HI 3
`define FLD_OBOOST_LO 2

// Reset values
`define RST_MODE 2'h0
`define RST_CHAN 4'h0
`define RST_PULSE 16'h0000
`define RST_BOOST 8'h00
`define RST_OBOOST 2'h0
`define RST_BIT 1'h0

`endif

// >>> rtl/pin_sync.v
// Purpose: Two-stage synchroniser for a group of slow control pins
// Assumes: Pins change rarely and each bit is independent
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Pins in, synchronised levels out
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            // One flip-flop pair per pin
            always @(posedge ref_clk) begin
                if (!rst_b) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= pin_in[i];
                    stage2 <= stage1;
                end
            end
            assign pin_out[i] = stage2;
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

// >>> rtl/term_pulse_timer.v
// Purpose: Times the input termination disconnect after a source switch
// Assumes: Start is a one-cycle pulse on the same clock
// Notes: A new start during a pulse restarts the full interval
`timescale 1ns/1ps
`default_nettype none
`include "switch_cfg_defs.vh"

module term_pulse_timer #(
    parameter [`TERM_TIMER_W-1:0] CYCLES = `TERM_PULSE_CYCLES
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Trigger and window
    input wire start,
    output reg active
);

    reg [`TERM_TIMER_W-1:0] remain;

    // Down counter; window closes one cycle after it reaches zero
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            remain <= {`TERM_TIMER_W{1'b0}};
            active <= 1'b0;
        end else if (start) begin
            remain <= CYCLES - 1'b1;
            active <= 1'b1;
        end else if (remain != {`TERM_TIMER_W{1'b0}}) begin
            remain <= remain - 1'b1;
        end else begin
            active <= 1'b0;
        end
    end

endmodule // term_pulse_timer

`default_nettype wire

// >>> rtl/switch_cfg_ctrl.v
// Purpose: Arbitrates switch settings between parallel pins and serial
// Assumes: A byte engine on ref_clk decodes the two-wire bus for us
// Notes: Serial takeover is sticky until rst_b is pulled low
`timescale 1ns/1ps
`default_nettype none
`include "switch_cfg_defs.vh"

module switch_cfg_ctrl #(
    parameter [`TERM_TIMER_W-1:0] TERM_PULSE_CYCLES = `TERM_PULSE_CYCLES
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Parallel control pins
    input wire [1:0] pin_group_select,
    input wire pin_global_boost,
    input wire pin_output_term,
    input wire pin_output_current,
    input wire [1:0] pin_output_boost,
    input wire pin_output_drive_enable,
    // Slave address straps
    input wire addr_strap_bit0,
    input wire addr_strap_bit1,
    input wire addr_strap_bit2,
    // Serial byte port from the bus engine
    input wire ser_addr_valid,
    input wire [6:0] ser_dev_addr,
    input wire ser_wr_valid,
    input wire [7:0] ser_wr_reg,
    input wire [7:0] ser_wr_data,
    input wire [7:0] ser_rd_reg,
    output reg ser_addr_match,
    output reg [7:0] ser_rd_data,
    // Routing settings
    output reg [1:0] fast_mode,
    output reg [3:0] fast_channel,
    output reg [1:0] aux_mode,
    output reg [3:0] aux_channel,
    // Input side settings
    output reg [15:0] input_term_connect,
    output reg [7:0] input_boost_select,
    // Output side settings
    output reg output_term_on,
    output reg output_current_select,
    output reg [1:0] output_boost_level,
    output reg output_drive_enable,
    // Status
    output reg serial_locked
);

    // Synchronised pins
    wire [7:0] pins_sync;
    wire [2:0] strap_sync;
    wire [1:0] s_group;
    wire s_boost;
    wire s_oterm;
    wire s_ocur;
    wire [1:0] s_oboost;
    wire s_oen;
    wire [6:0] own_addr;
    wire addr_hit;
    wire wr_take;
    wire pulse_active;

    // Serial register file
    reg [1:0] reg_fast_mode;
    reg [3:0] reg_fast_chan;
    reg [1:0] reg_aux_mode;
    reg [3:0] reg_aux_chan;
    reg [15:0] reg_pulse_en;
    reg reg_term_off;
    reg [7:0] reg_boost;
    reg reg_oterm;
    reg reg_ocur;
    reg [1:0] reg_oboost;
    reg reg_oen;
    reg selected;

    // Next values of the effective settings
    reg [1:0] next_fast_mode;
    reg [3:0] next_fast_channel;
    reg [1:0] next_aux_mode;
    reg [3:0] next_aux_channel;
    reg [15:0] next_input_term_connect;
    reg [7:0] next_input_boost_select;
    reg next_output_term_on;
    reg next_output_current_select;
    reg [1:0] next_output_boost_level;
    reg next_output_drive_enable;
    reg [7:0] next_ser_rd_data;
    reg switch_event;

    // Pins cross from outside the clock domain
    pin_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in({pin_group_select, pin_global_boost, pin_output_term,
            pin_output_current, pin_output_boost, pin_output_drive_enable}),
        .pin_out(pins_sync)
    );

    pin_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
        .pin_out(strap_sync)
    );

    assign s_group = pins_sync[7:6];
    assign s_boost = pins_sync[5];
    assign s_oterm = pins_sync[4];
    assign s_ocur = pins_sync[3];
    assign s_oboost = pins_sync[2:1];
    assign s_oen = pins_sync[0];

    // Own address; straps let eight devices share one bus
    assign own_addr = {`DEV_ADDR_UPPER, strap_sync};
    assign addr_hit = ser_addr_valid && (ser_dev_addr == own_addr);

    // Only whole bytes for this device are taken
    assign wr_take = ser_wr_valid && selected;

    // Device selection per frame and the sticky takeover
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            selected <= 1'b0;
            serial_locked <= 1'b0;
            ser_addr_match <= 1'b0;
        end else begin
            ser_addr_match <= addr_hit;
            if (ser_addr_valid) begin
                selected <= addr_hit;
            end
            // Never cleared here; only reset releases the pins
            if (addr_hit) begin
                serial_locked <= 1'b1;
            end
        end
    end

    // Serial registers track the pins until takeover, so that the
    // first serial frame starts from what the pins had set
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_fast_mode <= `RST_MODE;
            reg_fast_chan <= `RST_CHAN;
            reg_aux_mode <= `RST_MODE;
            reg_aux_chan <= `RST_CHAN;
            reg_pulse_en <= `RST_PULSE;
            reg_term_off <= `RST_BIT;
            reg_boost <= `RST_BOOST;
            reg_oterm <= `RST_BIT;
            reg_ocur <= `RST_BIT;
            reg_oboost <= `RST_OBOOST;
            reg_oen <= `RST_BIT;
        end else if (!serial_locked && !addr_hit) begin
            reg_fast_mode <= `MODE_QUAD;
            reg_fast_chan <= {2'h0, s_group};
            reg_aux_mode <= `MODE_QUAD;
            reg_aux_chan <= {2'h0, s_group};
            reg_pulse_en <= `RST_PULSE;
            reg_term_off <= `RST_BIT;
            reg_boost <= {8{s_boost}};
            reg_oterm <= s_oterm;
            reg_ocur <= s_ocur;
            reg_oboost <= s_oboost;
            reg_oen <= s_oen;
        end else if (wr_take) begin
            // Each register written from a complete byte
            case (ser_wr_reg)
                `REG_FAST_MODES: begin
                    // Reserved mode code keeps the old mode
                    if (ser_wr_data[`FLD_MODE_HI:`FLD_MODE_LO] !=
                        `MODE_BAD) begin
                        reg_fast_mode <=
                            ser_wr_data[`FLD_MODE_HI:`FLD_MODE_LO];
                    end
                    reg_fast_chan <=
                        ser_wr_data[`FLD_CHAN_HI:`FLD_CHAN_LO];
                    reg_oen <= ser_wr_data[`FLD_DRIVE_EN];
                end
                `REG_AUX_MODES: begin
                    if (ser_wr_data[`FLD_MODE_HI:`FLD_MODE_LO] !=
                        `MODE_BAD) begin
                        reg_aux_mode <=
                            ser_wr_data[`FLD_MODE_HI:`FLD_MODE_LO];
                    end
                    reg_aux_chan <= ser_wr_data[`FLD_CHAN_HI:`FLD_CHAN_LO];
                end
                `REG_PULSE_LO: begin
                    reg_pulse_en[7:0] <= ser_wr_data;
                end
                `REG_PULSE_HI: begin
                    reg_pulse_en[15:8] <= ser_wr_data;
                end
                `REG_RX_SET: begin
                    reg_term_off <= ser_wr_data[`FLD_TERM_OFF];
                end
                `REG_BOOST: begin
                    reg_boost <= ser_wr_data;
                end
                `REG_TX_SET: begin
                    reg_oterm <= ser_wr_data[`FLD_OTERM];
                    reg_ocur <= ser_wr_data[`FLD_OCUR];
                    reg_oboost <=
                        ser_wr_data[`FLD_OBOOST_HI:`FLD_OBOOST_LO];
                end
                default: begin
                    // Unmapped offsets are ignored
                end
            endcase
        end
    end

    // Effective settings: pins live before takeover, registers after
    always @* begin
        if (serial_locked) begin
            next_fast_mode = reg_fast_mode;
            next_fast_channel = reg_fast_chan;
            next_aux_mode = reg_aux_mode;
            next_aux_channel = reg_aux_chan;
            next_input_boost_select = reg_boost;
            next_output_term_on = reg_oterm;
            next_output_current_select = reg_ocur;
            next_output_boost_level = reg_oboost;
            next_output_drive_enable = reg_oen;
        end else begin
            // No strobe needed; pin levels pass straight through
            next_fast_mode = `MODE_QUAD;
            next_fast_channel = {2'h0, s_group};
            next_aux_mode = `MODE_QUAD;
            next_aux_channel = {2'h0, s_group};
            next_input_boost_select = {8{s_boost}};
            next_output_term_on = s_oterm;
            next_output_current_select = s_ocur;
            next_output_boost_level = s_oboost;
            next_output_drive_enable = s_oen;
        end
    end

    // A source switch is a change of the fast route while serial
    always @* begin
        switch_event = serial_locked &&
            ((next_fast_channel != fast_channel) ||
            (next_fast_mode != fast_mode));
    end

    // Shared 100 ms window for every pulsed input
    term_pulse_timer #(
        .CYCLES(TERM_PULSE_CYCLES)
    ) u_term_pulse_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start(switch_event),
        .active(pulse_active)
    );

    // Per input termination; pins never disconnect anything
    genvar ch;
    generate
        for (ch = 0; ch < 16; ch = ch + 1) begin : g_term
            always @* begin
                next_input_term_connect[ch] = !(serial_locked &&
                    (reg_term_off ||
                    (reg_pulse_en[ch] && pulse_active)));
            end
        end
    endgenerate

    // Read back of the serial registers only; lock state is not readable
    always @* begin
        case (ser_rd_reg)
            `REG_FAST_MODES: begin
                next_ser_rd_data = {reg_oen, 1'b0, reg_fast_mode,
                    reg_fast_chan};
            end
            `REG_AUX_MODES: begin
                next_ser_rd_data = {2'h0, reg_aux_mode, reg_aux_chan};
            end
            `REG_PULSE_LO: begin
                next_ser_rd_data = reg_pulse_en[7:0];
            end
            `REG_PULSE_HI: begin
                next_ser_rd_data = reg_pulse_en[15:8];
            end
            `REG_RX_SET: begin
                next_ser_rd_data = {7'h00, reg_term_off};
            end
            `REG_BOOST: begin
                next_ser_rd_data = reg_boost;
            end
            `REG_TX_SET: begin
                next_ser_rd_data = {4'h0, reg_oboost, reg_ocur, reg_oterm};
            end
            default: begin
                next_ser_rd_data = 8'h00;
            end
        endcase
    end

    // Output flops; drivers off, output termination off and inputs terminated during reset
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            fast_mode <= `RST_MODE;
            fast_channel <= `RST_CHAN;
            aux_mode <= `RST_MODE;
            aux_channel <= `RST_CHAN;
            input_term_connect <= 16'hFFFF;
            input_boost_select <= `RST_BOOST;
            output_term_on <= `RST_BIT;
            output_current_select <= `RST_BIT;
            output_boost_level <= `RST_OBOOST;
            output_drive_enable <= `RST_BIT;
            ser_rd_data <= 8'h00;
        end else begin
            fast_mode <= next_fast_mode;
            fast_channel <= next_fast_channel;
            aux_mode <= next_aux_mode;
            aux_channel <= next_aux_channel;
            input_term_connect <= next_input_term_connect;
            input_boost_select <= next_input_boost_select;
            output_term_on <= next_output_term_on;
            output_current_select <= next_output_current_select;
            output_boost_level <= next_output_boost_level;
            output_drive_enable <= next_output_drive_enable;
            ser_rd_data <= next_ser_rd_data;
        end
    end

endmodule // switch_cfg_ctrl

`default_nettype wire

// >>> verif/switch_cfg_chk_assertions.sv
// Purpose: Port-level checks for switch_cfg_ctrl
// Assumes: One clock, rst_b synchronous and active low
// Notes: Helper flops keep look-back checks clear of a reset
`timescale 1ns/1ps
`default_nettype none

module switch_cfg_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Parallel pins
    input wire logic [1:0] pin_group_select,
    input wire logic pin_global_boost,
    input wire logic pin_output_term,
    input wire logic pin_output_current,
    input wire logic [1:0] pin_output_boost,
    input wire logic pin_output_drive_enable,
    // Serial byte port
    input wire logic ser_addr_valid,
    input wire logic ser_wr_valid,
    input wire logic [7:0] ser_wr_reg,
    input wire logic [7:0] ser_wr_data,
    input wire logic ser_addr_match,
    // Settings and status
    input wire logic [1:0] fast_mode,
    input wire logic [3:0] fast_channel,
    input wire logic [15:0] input_term_connect,
    input wire logic [7:0] input_boost_select,
    input wire logic output_term_on,
    input wire logic output_current_select,
    input wire logic [1:0] output_boost_level,
    input wire logic output_drive_enable,
    input wire logic serial_locked
);
    logic [2:0] up;
    logic sel;

    // Cycles since reset; selection as seen from the match pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            up <= 3'h0;
            sel <= 1'b0;
        end else begin
            up <= (up == 3'h7) ? up : up + 3'h1;
            sel <= ser_addr_match | (sel & ~ser_addr_valid);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_lock_sticky: assert property (serial_locked |=> serial_locked)
        else $error("lock dropped without reset");
    a_match_cause: assert property (ser_addr_match |->
        $past(ser_addr_valid) && serial_locked)
        else $error("match without address byte");
    a_reset_dflt: assert property (disable iff (1'b0) !rst_b |=>
        !serial_locked && !output_drive_enable
        && input_term_connect == 16'hFFFF)
        else $error("reset defaults wrong");
    a_term_kept: assert property (!serial_locked |->
        input_term_connect == 16'hFFFF)
        else $error("termination opened under pin control");
    a_pin_follow: assert property (up == 3'h7 && !serial_locked |->
        {fast_mode, fast_channel, input_boost_select, output_term_on,
        output_current_select, output_boost_level, output_drive_enable} ==
        {4'h0, $past(pin_group_select, 3), {8{$past(pin_global_boost, 3)}},
        $past(pin_output_term, 3), $past(pin_output_current, 3),
        $past(pin_output_boost, 3), $past(pin_output_drive_enable, 3)})
        else $error("outputs do not follow pins");
    a_lock_freeze: assert property (up == 3'h7 && $past(serial_locked, 4)
        && !$past(ser_wr_valid, 2) |-> $stable({input_boost_select,
        output_term_on, output_current_select, output_boost_level,
        output_drive_enable, fast_channel}))
        else $error("setting moved after lock");
    a_tx_write: assert property (sel && ser_wr_valid &&
        ser_wr_reg == 8'h06 |-> ##2 {output_boost_level,
        output_current_select, output_term_on} == $past(ser_wr_data[3:0], 2))
        else $error("transmit settings not applied");
    a_mode_write: assert property (sel && ser_wr_valid &&
        ser_wr_reg == 8'h00 |-> ##2 {output_drive_enable, fast_channel} ==
        {$past(ser_wr_data[7], 2), $past(ser_wr_data[3:0], 2)} &&
        fast_mode == (($past(ser_wr_data[5:4], 2) == 2'h3) ?
        $past(fast_mode, 1) : $past(ser_wr_data[5:4], 2)))
        else $error("mode write not applied");
    a_term_off: assert property (sel && ser_wr_valid &&
        ser_wr_reg == 8'h04 && ser_wr_data[0] |-> ##2
        input_term_connect == 16'h0000)
        else $error("terminations not all off");
endmodule // switch_cfg_chk

bind switch_cfg_ctrl switch_cfg_chk chk_u (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .pin_group_select(pin_group_select),
    .pin_global_boost(pin_global_boost),
    .pin_output_term(pin_output_term),
    .pin_output_current(pin_output_current),
    .pin_output_boost(pin_output_boost),
    .pin_output_drive_enable(pin_output_drive_enable),
    .ser_addr_valid(ser_addr_valid), .ser_wr_valid(ser_wr_valid),
    .ser_wr_reg(ser_wr_reg), .ser_wr_data(ser_wr_data),
    .ser_addr_match(ser_addr_match), .fast_mode(fast_mode),
    .fast_channel(fast_channel), .input_term_connect(input_term_connect),
    .input_boost_select(input_boost_select),
    .output_term_on(output_term_on),
    .output_current_select(output_current_select),
    .output_boost_level(output_boost_level),
    .output_drive_enable(output_drive_enable),
    .serial_locked(serial_locked));
`default_nettype wire

// >>> verif/switch_host.sv
// Purpose: Host controller driving pins and the serial byte port
// Assumes: Changes land on falling edges, valid for one cycle per byte
// Notes: Released byte lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module switch_host (
    // Clock
    input wire logic ref_clk,
    // Straps, group, boost, oterm, ocur, oboost, enable
    output logic [10:0] pins,
    // Serial byte port
    output logic ser_addr_valid,
    output logic [6:0] ser_dev_addr,
    output logic ser_wr_valid,
    output logic [7:0] ser_wr_reg,
    output logic [7:0] ser_wr_data
);
    // Both terminations present, so 20 mA and drivers on
    initial begin
        pins = 11'h019;
        ser_addr_valid = 1'b0;
        ser_dev_addr = 7'h00;
        ser_wr_valid = 1'b0;
        ser_wr_reg = 8'h00;
        ser_wr_data = 8'h00;
    end

    // Static levels; the caller picks termination before enable
    task automatic set_pins(input logic [10:0] v);
        @(negedge ref_clk);
        pins = v;
    endtask

    // Address byte as handed over by the bus engine
    task automatic send_addr(input logic [6:0] a);
        @(negedge ref_clk);
        ser_dev_addr = a;
        ser_addr_valid = 1'b1;
        @(negedge ref_clk);
        ser_addr_valid = 1'b0;
        ser_dev_addr = ~a;
    endtask

    // Whole data byte with its register offset
    task automatic send_byte(input logic [7:0] r, input logic [7:0] d);
        @(negedge ref_clk);
        ser_wr_reg = r;
        ser_wr_data = d;
        ser_wr_valid = 1'b1;
        @(negedge ref_clk);
        ser_wr_valid = 1'b0;
        ser_wr_reg = ~r;
        ser_wr_data = ~d;
    endtask
endmodule // switch_host
`default_nettype wire

// >>> verif/switch_cfg_ctrl_test.sv
// Purpose: Self-checking bench for switch_cfg_ctrl
// Assumes: Pulse interval shortened to a few cycles
// Notes: Read offset tied to the transmit settings register
`timescale 1ns/1ps
`default_nettype none

module switch_cfg_ctrl_test;
    localparam int PULSE = 20;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    int mismatches = 0;
    int check_count = 0;
    wire [10:0] pins;
    wire ser_addr_valid, ser_wr_valid, ser_addr_match, serial_locked;
    wire [6:0] ser_dev_addr;
    wire [7:0] ser_wr_reg, ser_wr_data, ser_rd_data, input_boost_select;
    wire [1:0] fast_mode, aux_mode, output_boost_level;
    wire [3:0] fast_channel, aux_channel;
    wire [15:0] input_term_connect;
    wire output_term_on, output_current_select, output_drive_enable;

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    switch_host host_u (.ref_clk(ref_clk), .pins(pins),
        .ser_addr_valid(ser_addr_valid), .ser_dev_addr(ser_dev_addr),
        .ser_wr_valid(ser_wr_valid), .ser_wr_reg(ser_wr_reg),
        .ser_wr_data(ser_wr_data));

    switch_cfg_ctrl #(.TERM_PULSE_CYCLES(24'd20)) dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .pin_group_select(pins[7:6]), .pin_global_boost(pins[5]),
        .pin_output_term(pins[4]), .pin_output_current(pins[3]),
        .pin_output_boost(pins[2:1]), .pin_output_drive_enable(pins[0]),
        .addr_strap_bit0(pins[8]), .addr_strap_bit1(pins[9]),
        .addr_strap_bit2(pins[10]), .ser_addr_valid(ser_addr_valid),
        .ser_dev_addr(ser_dev_addr), .ser_wr_valid(ser_wr_valid),
        .ser_wr_reg(ser_wr_reg), .ser_wr_data(ser_wr_data),
        .ser_rd_reg(8'h06), .ser_addr_match(ser_addr_match),
        .ser_rd_data(ser_rd_data), .fast_mode(fast_mode),
        .fast_channel(fast_channel), .aux_mode(aux_mode),
        .aux_channel(aux_channel), .input_term_connect(input_term_connect),
        .input_boost_select(input_boost_select),
        .output_term_on(output_term_on),
        .output_current_select(output_current_select),
        .output_boost_level(output_boost_level),
        .output_drive_enable(output_drive_enable),
        .serial_locked(serial_locked));

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Ten-cycle reset, defaults checked before release
    task automatic t_reset;
        rst_b = 1'b0;
        cyc(10);
        chk({serial_locked, output_drive_enable, fast_mode}, 16'h0);
        chk(input_term_connect, 16'hFFFF);
        rst_b = 1'b1;
    endtask

    // Pin levels reach every setting with no strobe
    task automatic t_pins(input logic [7:0] v);
        host_u.set_pins({3'h0, v});
        cyc(4);
        chk({fast_mode, fast_channel}, {10'h0, v[7:6]});
        chk({aux_mode, aux_channel}, {10'h0, v[7:6]});
        chk(input_boost_select, {8'h0, {8{v[5]}}});
        chk({output_term_on, output_current_select}, {14'h0, v[4:3]});
        chk({output_boost_level, output_drive_enable}, {13'h0, v[2:0]});
        chk(input_term_connect, 16'hFFFF);
    endtask

    // Each strap setting, a miss and then a hit
    task automatic t_addr;
        for (int s = 0; s < 8; s++) begin
            // Setting pins move once locked; outputs must not follow
            host_u.set_pins({s[2:0], (s == 0) ? 8'h19 : 8'hE6});
            cyc(4);
            // Match pulse only stands one cycle, so look at once
            host_u.send_addr({4'h9, ~s[2:0]});
            chk({ser_addr_match, serial_locked}, {15'h0, s != 0});
            host_u.send_addr({4'h9, s[2:0]});
            chk({ser_addr_match, serial_locked}, 16'h3);
        end
        cyc(5);
        chk({output_boost_level, output_drive_enable}, 16'h1);
        chk({fast_channel, input_boost_select}, 16'h0000);
    endtask

    // Serial settings, every mode code, aux kept apart
    task automatic t_serial;
        host_u.send_byte(8'h06, 8'h0D);
        cyc(2);
        chk({output_boost_level, output_current_select, output_term_on},
            16'hD);
        chk(ser_rd_data[3:0], 16'hD);
        host_u.send_byte(8'h05, 8'hA5);
        cyc(2);
        chk(input_boost_select, 16'hA5);
        for (int m = 0; m < 4; m++) begin
            host_u.send_byte(8'h00, {2'h2, m[1:0], 4'h8 | m[3:0]});
            cyc(2);
            chk({fast_mode, fast_channel}, {10'h0, (m == 3) ? 2'h2 : m[1:0],
                4'h8 | m[3:0]});
            chk(output_drive_enable, 16'h1);
        end
        host_u.send_byte(8'h01, 8'h1C);
        cyc(2);
        chk({aux_mode, aux_channel, fast_mode}, 16'h72);
    endtask

    // Termination pulse on a switch, then all terminations off
    task automatic t_pulse;
        host_u.send_byte(8'h02, 8'h03);
        host_u.send_byte(8'h03, 8'h80);
        host_u.send_byte(8'h00, 8'h85);
        cyc(5);
        chk(input_term_connect, 16'h7FFC);
        cyc(PULSE + 10);
        chk(input_term_connect, 16'hFFFF);
        host_u.send_byte(8'h04, 8'h01);
        cyc(2);
        chk(input_term_connect, 16'h0000);
        host_u.send_byte(8'h04, 8'h00);
        cyc(2);
        chk(input_term_connect, 16'hFFFF);
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #50000;
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        t_reset();
        t_pins(8'h19);
        t_pins(8'hE6);
        t_addr();
        t_serial();
        t_pulse();
        t_reset();
        cyc(1);
        chk(serial_locked, 16'h0);
        t_pins(8'h59);
        close_out();
    end
endmodule // switch_cfg_ctrl_test
`default_nettype wire
